// *** src/cid_defs.svh ***
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH
// byte addresses of the registers on the axi4-lite slave
`define CID_OFF_STATUS 8'h00
`define CID_OFF_PROTECT 8'h04
`define CID_OFF_PINSEL 8'h08
`define CID_OFF_IRQROUTE 8'h0c
`define CID_OFF_EVROUTE 8'h10
// field positions
`define CID_BIT_INTRUSION 4
`define CID_BIT_LEVEL 5
`define CID_BIT_ALERT_SEL 6
`define CID_BIT_IRQ_PIN 2
`define CID_BIT_IRQ_CH2 4
`define CID_BIT_EV_ROUTE 5
// reset value of every configuration register
`define CID_CFG_RST 8'h00
// noise filter: stable time in ns and derived cycle count at 200 mhz
`define CID_FILT_NS 1000
`define CID_CLK_NS 5
`define CID_FILT_CYC ((`CID_FILT_NS + `CID_CLK_NS - 1) / `CID_CLK_NS)
`define CID_FILT_W 8
// axi responses
`define CID_RESP_OKAY 2'b00
`define CID_RESP_SLVERR 2'b10
`endif

// *** src/cid_pkg.sv ***
package cid_pkg;
  // axi4-lite request and answer groups
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } cid_wreq_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } cid_rans_t;
  // indications driven toward the system, all active low
  typedef struct packed {
    logic alert_n;
    logic irq_n;
    logic irq_ch2_n;
  } cid_ind_t;
endpackage

// *** src/cid_chassis_intrusion.sv ***
`include "cid_defs.svh"
module cid_chassis_intrusion (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // chassis switch pin
  input wire logic chassis_switch_in,
  // indications, active low
  output cid_pkg::cid_ind_t ind_r,
  // axi4-lite write address
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import cid_pkg::*;

  localparam int FILT_CYC = `CID_FILT_CYC;
  localparam logic [`CID_FILT_W-1:0] FILT_MAX =
    `CID_FILT_W'(FILT_CYC - 1);

  logic sync1_r, sync2_r;
  logic filt_r, filt_d_r;
  logic [`CID_FILT_W-1:0] cnt_r;
  logic sticky_r;
  logic [7:0] protect_r, pinsel_r, irqroute_r, evroute_r;
  logic aw_have_r, w_have_r;
  cid_wreq_t wreq_r;
  logic edge_seen;
  logic clr_req;
  logic wr_fire;

  // two-flop synchroniser; only sync2 is looked at by logic
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= chassis_switch_in;
      sync2_r <= sync1_r;
    end
  end

  // filter: a level must hold for FILT_CYC cycles before it is taken
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      filt_r <= 1'b0;
    end
    else if (sync2_r == filt_r)
      cnt_r <= '0;
    else if (cnt_r == FILT_MAX)
    begin
      filt_r <= sync2_r;
      cnt_r <= '0;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // delayed copy for edge detection; seeded at the first clock after reset, and both
  // copies reset low, so an open level at reset release is taken for an intrusion once filtered
  logic seeded_r;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_d_r <= 1'b0;
      seeded_r <= 1'b0;
    end
    else
    begin
      filt_d_r <= filt_r;
      seeded_r <= 1'b1;
    end
  end
  assign edge_seen = seeded_r && (filt_r != filt_d_r);

  // write acceptance: address and data taken in either order
  assign wr_fire = aw_have_r && w_have_r && !s_bvalid;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wreq_r <= '0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_have_r <= 1'b1;
        wreq_r.addr <= s_awaddr;
      end
      else if (wr_fire)
        aw_have_r <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_have_r <= 1'b1;
        wreq_r.data <= s_wdata;
        wreq_r.strb <= s_wstrb;
      end
      else if (wr_fire)
        w_have_r <= 1'b0;
    end
  end
  assign s_awready = !aw_have_r && !s_bvalid;
  assign s_wready = !w_have_r && !s_bvalid;

  // write response; unmapped addresses answer slverr
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= `CID_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= (wreq_r.addr > `CID_OFF_EVROUTE || wreq_r.addr[1:0] != 2'b00)
        ? `CID_RESP_SLVERR : `CID_RESP_OKAY;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end

  // configuration registers, byte lane 0 only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      protect_r <= `CID_CFG_RST;
      pinsel_r <= `CID_CFG_RST;
      irqroute_r <= `CID_CFG_RST;
      evroute_r <= `CID_CFG_RST;
    end
    else if (wr_fire && wreq_r.strb[0])
    begin
      case (wreq_r.addr)
        `CID_OFF_PROTECT: protect_r <= wreq_r.data[7:0];
        `CID_OFF_PINSEL: pinsel_r <= wreq_r.data[7:0];
        `CID_OFF_IRQROUTE: irqroute_r <= wreq_r.data[7:0];
        `CID_OFF_EVROUTE: evroute_r <= wreq_r.data[7:0];
        default: ;
      endcase
    end
  end

  // sticky bit: write-one-to-clear, a fresh edge wins over the clear
  assign clr_req = wr_fire && wreq_r.strb[0] &&
    wreq_r.addr == `CID_OFF_STATUS && wreq_r.data[`CID_BIT_INTRUSION];
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sticky_r <= 1'b0;
    else if (edge_seen)
      sticky_r <= 1'b1;
    else if (clr_req)
      sticky_r <= 1'b0;
  end

  // read channel; one cycle after arvalid the data is offered
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= `CID_RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rresp <= `CID_RESP_OKAY;
      s_rdata <= '0;
      case (s_araddr)
        `CID_OFF_STATUS:
        begin
          s_rdata[`CID_BIT_INTRUSION] <= sticky_r;
          s_rdata[`CID_BIT_LEVEL] <= filt_r;
        end
        `CID_OFF_PROTECT: s_rdata[7:0] <= protect_r;
        `CID_OFF_PINSEL: s_rdata[7:0] <= pinsel_r;
        `CID_OFF_IRQROUTE: s_rdata[7:0] <= irqroute_r;
        `CID_OFF_EVROUTE: s_rdata[7:0] <= evroute_r;
        default: s_rresp <= `CID_RESP_SLVERR;
      endcase
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end
  assign s_arready = !s_rvalid;

  // indications, registered; released (high) when not selected
  logic smi_act;
  assign smi_act = sticky_r && evroute_r[`CID_BIT_EV_ROUTE];
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ind_r <= 3'h7;
    else
    begin
      ind_r.alert_n <= !(protect_r[`CID_BIT_ALERT_SEL] && sticky_r);
      ind_r.irq_n <= !(pinsel_r[`CID_BIT_IRQ_PIN] && smi_act);
      ind_r.irq_ch2_n <= !(irqroute_r[`CID_BIT_IRQ_CH2] && smi_act);
    end
  end

  // assertions
  property p_alert;
    @(posedge ref_clk) disable iff (!arst_n)
    (protect_r[`CID_BIT_ALERT_SEL] && sticky_r) |=> !ind_r.alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not low");

  property p_alert_sel;
    @(posedge ref_clk) disable iff (!arst_n)
    !protect_r[`CID_BIT_ALERT_SEL] |=> ind_r.alert_n;
  endproperty
  a_alert_sel: assert property (p_alert_sel) else $error("alert unselected");

  property p_edge_set;
    @(posedge ref_clk) disable iff (!arst_n)
    edge_seen |=> sticky_r;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge lost");

  property p_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (clr_req && !edge_seen) |=> !sticky_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  sequence s_glitch;
    $changed(sync2_r) ##1 $changed(sync2_r);
  endsequence
  property p_filter;
    @(posedge ref_clk) disable iff (!arst_n)
    (filt_r == sync2_r) ##0 s_glitch |=> $stable(filt_r);
  endproperty
  a_filter: assert property (p_filter) else $error("glitch passed");

  property p_stable;
    @(posedge ref_clk) disable iff (!arst_n)
    $changed(filt_r) |-> $past(sync2_r, 2) == filt_r;
  endproperty
  a_stable: assert property (p_stable) else $error("level not stable");

  property p_irq_pin;
    @(posedge ref_clk) disable iff (!arst_n)
    (smi_act && pinsel_r[`CID_BIT_IRQ_PIN]) |=> !ind_r.irq_n;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin");

  property p_irq_ch2;
    @(posedge ref_clk) disable iff (!arst_n)
    !(smi_act && irqroute_r[`CID_BIT_IRQ_CH2]) |=> ind_r.irq_ch2_n;
  endproperty
  a_irq_ch2: assert property (p_irq_ch2) else $error("ch2 route");

  property p_route;
    @(posedge ref_clk) disable iff (!arst_n)
    !evroute_r[`CID_BIT_EV_ROUTE] |=> (ind_r.irq_n && ind_r.irq_ch2_n);
  endproperty
  a_route: assert property (p_route) else $error("unrouted irq");

  property p_release;
    @(posedge ref_clk) disable iff (!arst_n)
    !sticky_r |=> (ind_r.irq_n && ind_r.irq_ch2_n && ind_r.alert_n);
  endproperty
  a_release: assert property (p_release) else $error("not released");
endmodule

// *** bench/cid_switch_model.sv ***
// chassis switch as seen at the pin: a plain level that the bench opens
// or closes, plus a bounce request that shows the inverse level meanwhile
module cid_switch_model (
  // clock
  input wire logic ref_clk,
  // commanded chassis state and bounce request
  input wire logic open_cmd,
  input wire logic glitch_cmd,
  // switch pin
  output logic chassis_switch_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial chassis_switch_in = 1'b0;
  // a real switch bounces; the pin never shows an unknown level
  always @(posedge ref_clk)
  begin
    chassis_switch_in <= open_cmd ^ glitch_cmd;
  end
endmodule

// *** bench/cid_chassis_intrusion_test.sv ***
`include "cid_defs.svh"
module cid_chassis_intrusion_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cid_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic open_cmd = 1'b0;
  logic glitch_cmd = 1'b0;
  logic chassis_switch_in;
  cid_ind_t ind_r;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [31:0] s_rdata;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  cid_switch_model sw (.ref_clk(ref_clk), .open_cmd(open_cmd),
    .glitch_cmd(glitch_cmd), .chassis_switch_in(chassis_switch_in));
  cid_chassis_intrusion uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .chassis_switch_in(chassis_switch_in), .ind_r(ind_r),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));

  // 200 mhz clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang would otherwise stall the run forever
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // axi4-lite write; each half dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_awready && s_awvalid) s_awvalid <= 1'b0;
      if (s_wready && s_wvalid) s_wvalid <= 1'b0;
    end
    while (!(s_bvalid && s_bready));
    s_bready <= 1'b0;
    chk(32'(s_bresp), 32'(er), "bresp");
  endtask

  // axi4-lite read, data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_arready && s_arvalid) s_arvalid <= 1'b0;
    end
    while (!(s_rvalid && s_rready));
    s_rready <= 1'b0;
    chk(s_rdata, ed, "rdata");
    chk(32'(s_rresp), 32'(er), "rresp");
  endtask

  // filter, sync and indication latency all fit well inside this wait
  task automatic settle();
    repeat (240) @(posedge ref_clk);
  endtask

  task automatic t_idle();
    for (int a = 0; a <= 16; a += 4)
      rd(8'(a), 32'h0, `CID_RESP_OKAY);
    rd(8'h14, 32'h0, `CID_RESP_SLVERR);
    wr(8'h14, 32'hff, `CID_RESP_SLVERR);
    chk({29'h0, ind_r}, 32'h7, "idle ind");
    $display("test idle done");
  endtask

  task automatic t_glitch();
    glitch_cmd <= 1'b1;
    repeat (100) @(posedge ref_clk);
    glitch_cmd <= 1'b0;
    settle();
    rd(`CID_OFF_STATUS, 32'h0, `CID_RESP_OKAY);
    $display("test glitch done");
  endtask

  task automatic t_open();
    wr(`CID_OFF_PROTECT, 32'h40, `CID_RESP_OKAY);
    wr(`CID_OFF_PINSEL, 32'h04, `CID_RESP_OKAY);
    wr(`CID_OFF_IRQROUTE, 32'h10, `CID_RESP_OKAY);
    wr(`CID_OFF_EVROUTE, 32'h20, `CID_RESP_OKAY);
    open_cmd <= 1'b1;
    settle();
    rd(`CID_OFF_STATUS, 32'h30, `CID_RESP_OKAY);
    chk({29'h0, ind_r}, 32'h0, "all low");
    wr(`CID_OFF_STATUS, 32'h10, `CID_RESP_OKAY);
    rd(`CID_OFF_STATUS, 32'h20, `CID_RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, ind_r}, 32'h7, "released");
    $display("test open done");
  endtask

  task automatic t_close();
    wr(`CID_OFF_EVROUTE, 32'h00, `CID_RESP_OKAY);
    open_cmd <= 1'b0;
    settle();
    rd(`CID_OFF_STATUS, 32'h10, `CID_RESP_OKAY);
    chk({29'h0, ind_r}, 32'h3, "alert only");
    wr(`CID_OFF_PROTECT, 32'h00, `CID_RESP_OKAY);
    wr(`CID_OFF_IRQROUTE, 32'h00, `CID_RESP_OKAY);
    wr(`CID_OFF_EVROUTE, 32'h20, `CID_RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, ind_r}, 32'h5, "pin irq only");
    wr(`CID_OFF_STATUS, 32'h10, `CID_RESP_OKAY);
    rd(`CID_OFF_STATUS, 32'h0, `CID_RESP_OKAY);
    $display("test close done");
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_idle();
    t_glitch();
    t_open();
    t_close();
    print_verdict();
  end
endmodule
